//--- hw/sram_write_ctrl.sv
// Purpose: Byte-lane write control of a synchronous flow-through SRAM
// Assumes: Bus pins are driven by a controller on the same pclk
// Notes: Drives a registered write port toward the storage array
// ============================================================
// Hazards and limits
// - The SRAM pins are taken as pclk-domain logic, so no synchroniser
//   sits on them; a controller on another clock needs its own crossing.
// - Every pin is captured on every edge; a read cycle is simply a
//   captured command whose lane mask comes out empty.
// - The array write starts one edge after capture, so the write port
//   lags the pins by two edges in all.
// - Back-to-back writes each start their own pulse; with a pulse longer
//   than one cycle a new start cuts the old one short and raises the
//   overrun flag, which software clears by writing one.
// - Changing the organisation while writes are in flight re-masks the
//   captured command, so do it only while the pins are idle.
// - An organisation code of 3 is treated as the four-lane parity part.
// - Unmapped register offsets answer with pslverr and read as zero;
//   writes to them change nothing.
// - A COUNT clear in the same cycle as a stored write leaves one.
// - COUNT wraps silently once it passes its top value.
// - STATUS busy follows the pulse timer, not the pins.
// - Parity bits of absent lanes are forced to zero on the port.

// ============================================================
// Top module
module sram_write_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sram_wr_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [sram_wr_pkg::ADDR_W-1:0] sync_addr,
  input wire logic lane_a_write_n,
  input wire logic lane_b_write_n,
  input wire logic lane_c_write_n,
  input wire logic lane_d_write_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_qualifier_n,
  input wire logic [7:0] data_lane_a,
  input wire logic [7:0] data_lane_b,
  input wire logic [7:0] data_lane_c,
  input wire logic [7:0] data_lane_d,
  input wire logic parity_lane_a,
  input wire logic parity_lane_b,
  input wire logic parity_lane_c,
  input wire logic parity_lane_d,
  output sram_wr_pkg::array_wr_t array_wr
);
  import sram_wr_pkg::*;

  // ============================================================
  // Types and state
  typedef struct packed {
    pin_cmd_t cmd;
    org_t org;
    logic wr_en;
    logic ovr;
    logic [LANES-1:0] last_byte;
    logic [LANES-1:0] last_par;
    logic [31:0] count;
    logic [ADDR_W-1:0] last_addr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_q;
  state_t s_d;
  pin_cmd_t pins;
  array_wr_t req;
  logic start;
  logic t_busy;
  logic t_accept;
  logic [LANES-1:0] byte_mask;
  logic [LANES-1:0] par_mask;
  logic [31:0] rd_val;
  logic rd_hit;
  logic acc;

  // ============================================================
  // Functions

  // Lanes the organisation has
  // Lanes c and d are absent from the two-lane part
  function automatic logic [LANES-1:0] org_lanes(input org_t org);
    org_lanes = (org == ORG_X18) ? X18_LANES : ALL_LANES;
  endfunction

  // Lanes that carry parity storage
  function automatic logic [LANES-1:0] org_par(input org_t org);
    case (org)
      ORG_X18: org_par = X18_LANES;
      ORG_X36: org_par = ALL_LANES;
      default: org_par = NO_LANES;
    endcase
  endfunction

  // Byte lanes a captured command writes
  // Global write outranks the qualifier, which outranks the lanes
  function automatic logic [LANES-1:0] lane_sel(input pin_cmd_t c,
                                                input org_t org);
    logic [LANES-1:0] m;
    m = NO_LANES;
    if (!c.all_n) begin
      m = ALL_LANES;
    end else if (!c.qual_n) begin
      m = ~c.lane_n;
    end
    lane_sel = m & org_lanes(org);
  endfunction

  // ============================================================
  // Pin gathering
  // Packed d..a from the top so that bit i pairs with lane i
  always_comb begin
    pins.addr = sync_addr;
    pins.lane_n = {lane_d_write_n, lane_c_write_n,
                   lane_b_write_n, lane_a_write_n};
    pins.all_n = all_lanes_write_n;
    pins.qual_n = lane_write_qualifier_n;
    pins.data = {data_lane_d, data_lane_c, data_lane_b, data_lane_a};
    pins.par = {parity_lane_d, parity_lane_c,
                parity_lane_b, parity_lane_a};
  end

  // ============================================================
  // Write decode from registered command
  // A read cycle gives an empty mask and starts nothing
  always_comb begin
    byte_mask = lane_sel(s_q.cmd, s_q.org);
    par_mask = byte_mask & org_par(s_q.org);
    req.en = 1'b1;
    req.addr = s_q.cmd.addr;
    if (s_q.org != ORG_X18) begin
      req.addr[ADDR_W-1] = 1'b0; // Four-lane parts are half as deep
    end
    req.data = s_q.cmd.data;
    req.par = s_q.cmd.par & org_par(s_q.org);
    req.byte_we = byte_mask;
    req.par_we = par_mask;
    start = s_q.wr_en && (byte_mask != NO_LANES);
  end

  // ============================================================
  // Self-timed array write
  // The timer holds one write for the pulse, then drops every enable
  write_pulse_timer #(
    .PULSE_CYCLES(WRITE_PULSE_CYCLES)
  ) write_pulse_timer_i (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .req(req),
    .wr(array_wr),
    .busy(t_busy),
    .can_accept(t_accept)
  );

  // ============================================================
  // Register read decode
  // Unmapped offsets answer with an error and zero data
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (paddr)
      CTRL_OFS: begin
        rd_val[CTRL_ORG_LSB +: 2] = s_q.org;
        rd_val[CTRL_EN_BIT] = s_q.wr_en;
      end
      STATUS_OFS: begin
        rd_val[ST_BUSY_BIT] = t_busy;
        rd_val[ST_OVR_BIT] = s_q.ovr;
        rd_val[ST_BYTE_LSB +: LANES] = s_q.last_byte;
        rd_val[ST_PAR_LSB +: LANES] = s_q.last_par;
      end
      COUNT_OFS: begin
        rd_val = s_q.count;
      end
      LADDR_OFS: begin
        rd_val[ADDR_W-1:0] = s_q.last_addr;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Access phase that completes at this edge
  assign acc = psel && penable && s_q.pready;

  // ============================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Capture every bus input on each rising edge
    s_d.cmd = pins;

    // One wait state, then answer from registers
    s_d.pready = psel && penable && !s_q.pready;
    if (psel && penable && !s_q.pready) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
      s_d.pslverr = !rd_hit;
    end

    // Register writes take effect at the completing edge
    if (acc && pwrite) begin
      case (paddr)
        CTRL_OFS: begin
          if (pwdata[CTRL_ORG_LSB +: 2] == ORG_X18) begin
            s_d.org = ORG_X18;
          end else if (pwdata[CTRL_ORG_LSB +: 2] == ORG_X32) begin
            s_d.org = ORG_X32;
          end else begin
            s_d.org = ORG_X36;
          end
          s_d.wr_en = pwdata[CTRL_EN_BIT];
        end
        STATUS_OFS: begin
          if (pwdata[ST_OVR_BIT]) begin
            s_d.ovr = 1'b0;
          end
        end
        COUNT_OFS: begin
          s_d.count = 32'h0000_0000;
        end
        default: begin
          s_d.org = s_q.org;
        end
      endcase
    end

    // Track stored writes; hardware set beats software clear
    if (start) begin
      s_d.count = s_d.count + 32'h0000_0001;
      s_d.last_byte = byte_mask;
      s_d.last_par = par_mask;
      s_d.last_addr = req.addr;
      if (!t_accept) begin
        s_d.ovr = 1'b1;
      end
    end
  end

  // ============================================================
  // State register
  // Captured controls reset to a read cycle, so no write follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.cmd.lane_n <= ALL_LANES;
      s_q.cmd.all_n <= 1'b1;
      s_q.cmd.qual_n <= 1'b1;
      s_q.org <= CTRL_ORG_RST;
      s_q.wr_en <= CTRL_EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule // sram_write_ctrl

//--- hw/sram_wr_pkg.sv
// Purpose: Shared constants and carriers for the SRAM write-control block
// Assumes: One clock pclk at 200 MHz, asynchronous active-low reset
// Notes: Register offsets are byte addresses on a 32-bit APB word map

// ============================================================
// Package
package sram_wr_pkg;

  // Widths of the SRAM side and of the APB address
  localparam int ADDR_W = 17;
  localparam int LANES = 4;
  localparam int DATA_W = 8 * LANES;
  localparam int APB_AW = 12;

  // Register offsets
  localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
  localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;
  localparam logic [APB_AW-1:0] COUNT_OFS = 12'h008;
  localparam logic [APB_AW-1:0] LADDR_OFS = 12'h00c;

  // Word organisations
  typedef enum logic [1:0] {
    ORG_X18 = 2'b00,
    ORG_X32 = 2'b01,
    ORG_X36 = 2'b10
  } org_t;

  // Control register fields and reset values
  localparam int CTRL_ORG_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam org_t CTRL_ORG_RST = ORG_X36;
  localparam logic CTRL_EN_RST = 1'b1;

  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_OVR_BIT = 1;
  localparam int ST_BYTE_LSB = 4;
  localparam int ST_PAR_LSB = 8;

  // Lane masks
  localparam logic [LANES-1:0] X18_LANES = 4'h3;
  localparam logic [LANES-1:0] ALL_LANES = 4'hf;
  localparam logic [LANES-1:0] NO_LANES = 4'h0;

  // Self-timed array write length, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int WRITE_TIME_NS = 5;
  localparam int WRITE_PULSE_RAW =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_PULSE_CYCLES =
    (WRITE_PULSE_RAW < 1) ? 1 : WRITE_PULSE_RAW;

  // Bus-side command sampled at a rising edge
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_n;
    logic all_n;
    logic qual_n;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] par;
  } pin_cmd_t;

  // Write presented to the storage array
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANES-1:0] par;
    logic [LANES-1:0] byte_we;
    logic [LANES-1:0] par_we;
  } array_wr_t;

endpackage

//--- hw/write_pulse_timer.sv
// Purpose: Self-timed array write; holds one write for a fixed pulse
// Assumes: Requests come from logic on pclk
// Notes: A start while a pulse is still running replaces it

// ============================================================
// Write pulse timer
module write_pulse_timer #(
  parameter int unsigned PULSE_CYCLES = sram_wr_pkg::WRITE_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire sram_wr_pkg::array_wr_t req,
  output sram_wr_pkg::array_wr_t wr,
  output logic busy,
  output logic can_accept
);
  import sram_wr_pkg::*;

  typedef struct packed {
    array_wr_t wr;
    logic [7:0] cnt;
    logic busy;
  } tstate_t;

  tstate_t s_q;
  tstate_t s_d;

  // Load on start, count down, then drop every write enable
  always_comb begin
    s_d = s_q;
    if (start) begin
      s_d.wr = req;
      s_d.wr.en = 1'b1;
      s_d.cnt = 8'(PULSE_CYCLES - 1);
      s_d.busy = 1'b1;
    end else if (s_q.busy) begin
      if (s_q.cnt == 8'h00) begin
        s_d.busy = 1'b0;
        s_d.wr.en = 1'b0;
        s_d.wr.byte_we = NO_LANES;
        s_d.wr.par_we = NO_LANES;
      end else begin
        s_d.cnt = s_q.cnt - 8'h01;
      end
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wr = s_q.wr;
  assign busy = s_q.busy;
  assign can_accept = ~s_q.busy | (s_q.cnt == 8'h00);

endmodule // write_pulse_timer

//--- verif/sram_host_model.sv
// Purpose: Host controller model driving the SRAM write pins
// Assumes: Bench hands over one command per cycle with go high
// Notes: Idle address, data and parity lines show the inverse of the last word, never a hold

// ============================================================
// Host model
module sram_host_model (
  input wire logic pclk,
  input wire logic go,
  input wire sram_wr_pkg::pin_cmd_t cmd,
  output sram_wr_pkg::pin_cmd_t pins
);
  timeunit 1ns;
  timeprecision 100ps;
  import sram_wr_pkg::*;
  pin_cmd_t last_q = '0;

  // Remember the last driven word
  always_ff @(posedge pclk) begin
    if (go) begin
      last_q <= cmd;
    end
  end

  // Stable across the edge while driving, read cycle otherwise
  always_comb begin
    pins = go ? cmd : ~last_q;
    if (!go) begin
      pins.lane_n = ALL_LANES;
      pins.all_n = 1'h1;
      pins.qual_n = 1'h1;
    end
  end
endmodule // sram_host_model

//--- verif/sram_write_ctrl_monitor.sv
// Purpose: Port assertions for the SRAM write-control block
// Assumes: CTRL is written only while the SRAM pins are idle
// Notes: Follows CTRL writes to predict the lane masks

// ============================================================
// Checker
module sram_write_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [sram_wr_pkg::APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [sram_wr_pkg::ADDR_W-1:0] sync_addr,
  input wire logic lane_a_write_n,
  input wire logic lane_b_write_n,
  input wire logic lane_c_write_n,
  input wire logic lane_d_write_n,
  input wire logic all_lanes_write_n,
  input wire logic lane_write_qualifier_n,
  input wire logic [7:0] data_lane_a,
  input wire logic parity_lane_a,
  input wire sram_wr_pkg::array_wr_t array_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  import sram_wr_pkg::*;
  logic [1:0] org_q;
  logic wen_q;
  logic [1:0] live_q;
  logic x18;
  logic [3:0] exp_we;
  logic [3:0] exp_pw;
  logic [ADDR_W-1:0] exp_addr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Shadow of CTRL and a settle count after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      org_q <= 2'h2;
      wen_q <= 1'h1;
      live_q <= 2'h0;
    end else begin
      if (live_q != 2'h3) begin
        live_q <= live_q + 2'h1;
      end
      if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
        org_q <= pwdata[1:0];
        wen_q <= pwdata[CTRL_EN_BIT];
      end
    end
  end

  // Predicted masks and address from the live pins
  always_comb begin
    x18 = (org_q == ORG_X18);
    exp_we = NO_LANES;
    if (!all_lanes_write_n) begin
      exp_we = ALL_LANES;
    end else if (!lane_write_qualifier_n) begin
      exp_we = ~{lane_d_write_n, lane_c_write_n, lane_b_write_n,
        lane_a_write_n};
    end
    exp_we = wen_q ? (exp_we & (x18 ? X18_LANES : ALL_LANES)) : NO_LANES;
    exp_pw = (org_q == ORG_X32) ? NO_LANES : exp_we;
    exp_addr = sync_addr;
    exp_addr[ADDR_W-1] = exp_addr[ADDR_W-1] & x18;
  end

  a_lane_mask: assert property (live_q[1] |->
    array_wr.byte_we == $past(exp_we, 2)) else $error("lane mask wrong");
  a_parity_mask: assert property (live_q[1] |->
    array_wr.par_we == $past(exp_pw, 2)) else $error("parity mask wrong");
  a_write_pulse: assert property (live_q[1] |->
    array_wr.en == ($past(exp_we, 2) != 0)) else $error("pulse wrong");
  a_global_full: assert property (!all_lanes_write_n && wen_q &&
    !x18 |-> ##2 array_wr.byte_we == ALL_LANES) else $error("not full");
  a_addr_taken: assert property (live_q[1] && array_wr.en |->
    array_wr.addr == $past(exp_addr, 2)) else $error("address wrong");
  a_data_taken: assert property (array_wr.byte_we[0] |->
    array_wr.data[7:0] == $past(data_lane_a, 2)) else $error("data wrong");
  a_parity_taken: assert property (array_wr.par_we[0] |->
    array_wr.par[0] == $past(parity_lane_a, 2)) else $error("parity wrong");
  a_apb_wait: assert property (psel && $rose(penable) |->
    !pready ##1 pready) else $error("wait state wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
endmodule // sram_write_ctrl_monitor

bind sram_write_ctrl sram_write_ctrl_monitor sram_write_ctrl_monitor_i (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .sync_addr, .lane_a_write_n, .lane_b_write_n, .lane_c_write_n,
  .lane_d_write_n, .all_lanes_write_n, .lane_write_qualifier_n,
  .data_lane_a, .parity_lane_a, .array_wr);

//--- verif/test_sram_write_ctrl.sv
// Purpose: Self-checking bench for the SRAM write-control block
// Assumes: CTRL changes only while no SRAM write is in flight
// Notes: Expected masks are rebuilt from the lane rules here

// ============================================================
// Bench
module test_sram_write_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import sram_wr_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, go = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] org = 2'h2;
  logic wen = 1'h1;
  pin_cmd_t cmd = '0, pins;
  array_wr_t array_wr;
  int miscompares = 0, comparisons = 0;

  sram_host_model sram_host_model_i (.pclk, .go, .cmd, .pins);
  sram_write_ctrl sram_write_ctrl_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .sync_addr(pins.addr),
    .lane_a_write_n(pins.lane_n[0]), .lane_b_write_n(pins.lane_n[1]),
    .lane_c_write_n(pins.lane_n[2]), .lane_d_write_n(pins.lane_n[3]),
    .all_lanes_write_n(pins.all_n), .lane_write_qualifier_n(pins.qual_n),
    .data_lane_a(pins.data[7:0]), .data_lane_b(pins.data[15:8]),
    .data_lane_c(pins.data[23:16]), .data_lane_d(pins.data[31:24]),
    .parity_lane_a(pins.par[0]), .parity_lane_b(pins.par[1]),
    .parity_lane_c(pins.par[2]), .parity_lane_d(pins.par[3]), .array_wr);

  // Clock
  initial forever #2.5 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // Ready is read at the edge itself; the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic put(input pin_cmd_t c);
    @(posedge pclk);
    cmd <= c;
    go <= 1'h1;
  endtask

  task automatic stop;
    @(posedge pclk);
    go <= 1'h0;
    #1;
  endtask

  // Compare the array port with the lanes that the pins select
  task automatic look(input pin_cmd_t c);
    logic [3:0] m, p;
    logic [31:0] dm;
    logic [ADDR_W-1:0] a;
    m = !c.all_n ? ALL_LANES : (!c.qual_n ? ~c.lane_n : NO_LANES);
    if (org == 2'h0) m = m & X18_LANES;
    if (!wen) m = NO_LANES;
    p = (org == 2'h1) ? NO_LANES : m;
    dm = {{8{m[3]}}, {8{m[2]}}, {8{m[1]}}, {8{m[0]}}};
    a = c.addr;
    if (org != 2'h0) a[ADDR_W-1] = 1'h0;
    check({array_wr.en, array_wr.byte_we}, {|m, m});
    check(array_wr.par_we, p);
    if (|m) begin
      check(array_wr.addr, a);
      check(array_wr.data & dm, c.data & dm);
      check(array_wr.par & p, c.par & p);
    end
  endtask

  task automatic test_regs;
    apb(1'h0, CTRL_OFS, 32'h0, rd, err);
    check(rd, 32'h6);
    apb(1'h0, 12'h010, 32'h0, rd, err);
    check({rd[30:0], err}, 32'h1);
    $display("test regs done");
  endtask

  // Every organisation, writes disabled last, six lane patterns each
  task automatic test_lanes;
    pin_cmd_t c;
    for (int o = 0; o < 5; o++) begin
      org = (o == 4) ? 2'h2 : o[1:0];
      wen = (o != 4);
      apb(1'h1, CTRL_OFS, {29'h0, wen, org}, rd, err);
      for (int i = 0; i < 6; i++) begin
        c.addr = {1'h1, 12'h0, i[3:0]};
        c.lane_n = (i < 4) ? ~(4'h1 << i) : {4{i == 4}};
        c.all_n = (i != 4);
        c.qual_n = (i >= 4);
        c.data = 32'ha5c3_1e70 ^ i;
        c.par = 4'ha ^ i[3:0];
        put(c);
        stop();
        @(posedge pclk);
        #1;
        look(c);
      end
    end
    $display("test lanes done");
  endtask

  task automatic test_back_to_back;
    pin_cmd_t c1, c2;
    c1 = '{17'h1_2345, 4'hf, 1'h0, 1'h1, 32'h1122_3344, 4'h9};
    c2 = '{17'h0_0abc, 4'hd, 1'h1, 1'h0, 32'h5566_7788, 4'h6};
    org = 2'h2;
    wen = 1'h1;
    apb(1'h1, CTRL_OFS, 32'h6, rd, err);
    apb(1'h1, COUNT_OFS, 32'h0, rd, err);
    put(c1);
    put(c2);
    stop();
    look(c1);
    @(posedge pclk);
    #1;
    look(c2);
    apb(1'h0, COUNT_OFS, 32'h0, rd, err);
    check(rd, 32'h2);
    apb(1'h0, LADDR_OFS, 32'h0, rd, err);
    check(rd, {15'h0, c2.addr});
    apb(1'h0, STATUS_OFS, 32'h0, rd, err);
    check(rd, 32'h0000_0220);
    $display("test back_to_back done");
  endtask

  task automatic summarize;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    test_regs();
    test_lanes();
    test_back_to_back();
    summarize();
  end

  // Watchdog
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule // test_sram_write_ctrl
